/* amp_remote_defines.svh */
// shared constants of the amplifier remote control decoder
// assumes a 100 MHz hclk and a word-wide AHB-Lite register port
`ifndef AMP_REMOTE_DEFINES_SVH
`define AMP_REMOTE_DEFINES_SVH

// ==========================================================
// gain codes, as driven on the remote gain lines
`define GAIN_X10000        2'h2
`define GAIN_X1000         2'h0
`define GAIN_X100          2'h1
`define GAIN_UNDEF         2'h3
`define GAIN_REMOTE_POS    2'h0

// ==========================================================
// cut-off codes, as driven on the remote cut-off lines
`define CUT_100HZ          4'h0
`define CUT_1MHZ           4'h8
`define CUT_REMOTE_POS     4'h0

// ==========================================================
// timing
`define CLK_PERIOD_NS      10
`define GAIN_SETTLE_NS     100000
`define GAIN_SETTLE_CYC    (`GAIN_SETTLE_NS / `CLK_PERIOD_NS)
`define STABLE_CYC         16

// ==========================================================
// register byte offsets and reset values
`define REG_STATUS         8'h00
`define REG_IRQ_STATUS     8'h04
`define REG_IRQ_MASK       8'h08
`define REG_CTRL           8'h0C
`define CTRL_RESET         2'h3
`define IRQ_MASK_RESET     5'h00
`define CTRL_GAIN_EN       0
`define CTRL_CUT_EN        1

// ==========================================================
// event bit positions in the interrupt status and mask
`define EV_GAIN            0
`define EV_CUT             1
`define EV_OVL             2
`define EV_COMP_LOST       3
`define EV_BAD_CODE        4
`define EV_W               5

`endif

/* amp_remote_pkg.sv */
// types shared by the remote control decoder files
// assumes amp_remote_defines.svh supplies the numeric constants
package amp_remote_pkg;

  // ========================================================
  // settling timer states
  typedef enum logic [0:0] {
    SETTLE_IDLE,
    SETTLE_RUN
  } settle_state_t;

endpackage

/* sel_debounce.sv */
// synchroniser and stability filter for a group of select lines
// assumes inputs may change at any time relative to hclk
`timescale 1ns/1ps
`include "amp_remote_defines.svh"

module sel_debounce #(
  parameter int WIDTH  = 4,
  parameter int STABLE = `STABLE_CYC
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  localparam int CW = $clog2(STABLE + 1);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] dout_q;
  logic [WIDTH-1:0] dout_d;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;

  // ========================================================
  // stability count: restarts on any change of the synced lines
  always_comb begin
    cnt_d  = cnt_q;
    dout_d = dout_q;
    if (sync_q != prev_q) begin
      cnt_d = '0;
    end else if (cnt_q != CW'(STABLE)) begin
      cnt_d = cnt_q + CW'(1);
    end else begin
      dout_d = prev_q;           // only a settled value passes
    end
  end

  // ========================================================
  // two-flop synchroniser, then the filter registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
      dout_q <= '0;
      cnt_q  <= '0;
    end else if (ce) begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
      dout_q <= dout_d;
      cnt_q  <= cnt_d;
    end
  end

  assign dout = dout_q;

endmodule

/* settle_timer.sv */
// one-shot timer that marks the gain settling window
// assumes start is a one-cycle pulse in the hclk domain
`timescale 1ns/1ps
`include "amp_remote_defines.svh"

module settle_timer #(
  parameter int CYCLES = `GAIN_SETTLE_CYC
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic start,
  output logic      busy
);

  localparam int CW = $clog2(CYCLES + 1);

  amp_remote_pkg::settle_state_t state_q;
  amp_remote_pkg::settle_state_t state_d;
  logic [CW-1:0]                 cnt_q;
  logic [CW-1:0]                 cnt_d;

  // ========================================================
  // a new start restarts the window from the full count
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      amp_remote_pkg::SETTLE_IDLE: begin
        if (start) begin
          state_d = amp_remote_pkg::SETTLE_RUN;
          cnt_d   = CW'(CYCLES - 1);
        end
      end
      amp_remote_pkg::SETTLE_RUN: begin
        if (start) begin
          cnt_d = CW'(CYCLES - 1);
        end else if (cnt_q == '0) begin
          state_d = amp_remote_pkg::SETTLE_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
    endcase
  end

  // ========================================================
  // state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= amp_remote_pkg::SETTLE_IDLE;
      cnt_q   <= '0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign busy = (state_q == amp_remote_pkg::SETTLE_RUN);

endmodule

/* amp_remote_decoder.sv */
// remote control decoder of a differential amplifier: select lines,
// manual selectors, status outputs and an AHB-Lite register port
// assumes all inputs synchronous to hclk except the remote select lines
`timescale 1ns/1ps
`include "amp_remote_defines.svh"

// Operation
// - remote gain lines act only while the gain selector is in x1'000.
// - remote cut-off lines act only while the cut-off knob is at 100 Hz.
// - gain and cut-off each choose remote or manual on their own.
// - gain code 10 gives x10'000, 00 gives x1'000, 01 gives x100.
// - cut-off codes 1000 down to 0000 give 1 MHz down to 100 Hz.
// - a gain change is marked settling for 100 us before it is relied on.
// - both status outputs pull low while their condition is true.
// - overload shows on output over range, common mode or failed trim.
// - offset-compensated shows while the offset stays within window.
module amp_remote_decoder #(
  parameter int SETTLE_CYC = `GAIN_SETTLE_CYC,
  parameter int STABLE_CYC = `STABLE_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        gain_sel_bit0,
  input  wire logic        gain_sel_bit1,
  input  wire logic        cutoff_sel_bit0,
  input  wire logic        cutoff_sel_bit1,
  input  wire logic        cutoff_sel_bit2,
  input  wire logic        cutoff_sel_bit3,
  input  wire logic [1:0]  gain_switch_pos,
  input  wire logic [3:0]  cutoff_switch_pos,
  input  wire logic        out_over_pos,
  input  wire logic        out_over_neg,
  input  wire logic        common_mode_over,
  input  wire logic        offset_trim_fail,
  input  wire logic        offset_in_window,
  output logic      [1:0]  gain_code,
  output logic      [3:0]  cutoff_code,
  output logic             gain_settling,
  output logic             overload_flag_n,
  output logic             overload_flag_oe_n,
  output logic             offset_ok_n,
  output logic             offset_ok_oe_n,
  output logic             irq
);

  // ========================================================
  // declarations
  logic [1:0]        rem_gain;
  logic [3:0]        rem_cut;
  logic              settle_busy;
  logic              gain_remote;
  logic              cut_remote;
  logic              ovl_cond;
  logic [`EV_W-1:0]  events;
  logic [1:0]        gain_q;
  logic [1:0]        gain_d;
  logic [3:0]        cut_q;
  logic [3:0]        cut_d;
  logic              ovl_q;
  logic              comp_q;
  logic              settle_q;
  logic [1:0]        ctrl_q;
  logic [1:0]        ctrl_d;
  logic [`EV_W-1:0]  ist_q;
  logic [`EV_W-1:0]  ist_d;
  logic [`EV_W-1:0]  mask_q;
  logic [`EV_W-1:0]  mask_d;
  logic              irq_q;
  logic              wr_q;
  logic [7:0]        addr_q;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic              ready_q;
  logic              addr_ph;
  logic              wr_ph;
  logic [31:0]       status_w;

  // ========================================================
  // remote line conditioning
  sel_debounce #(
    .WIDTH  (2),
    .STABLE (STABLE_CYC)
  ) u_gain_db (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .din     ({gain_sel_bit1, gain_sel_bit0}),
    .dout    (rem_gain)
  );

  sel_debounce #(
    .WIDTH  (4),
    .STABLE (STABLE_CYC)
  ) u_cut_db (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .din     ({cutoff_sel_bit3, cutoff_sel_bit2,
               cutoff_sel_bit1, cutoff_sel_bit0}),
    .dout    (rem_cut)
  );

  settle_timer #(
    .CYCLES (SETTLE_CYC)
  ) u_settle (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .start   (gain_d != gain_q),
    .busy    (settle_busy)
  );

  // ========================================================
  // remote or manual choice, each path on its own
  assign gain_remote = (gain_switch_pos == `GAIN_REMOTE_POS)
                     && ctrl_q[`CTRL_GAIN_EN];
  assign cut_remote  = (cutoff_switch_pos == `CUT_REMOTE_POS)
                     && ctrl_q[`CTRL_CUT_EN];

  // ========================================================
  // gain and cut-off selection
  always_comb begin
    gain_d = gain_switch_pos;
    if (gain_remote) begin
      if (rem_gain == `GAIN_UNDEF) begin
        gain_d = `GAIN_X1000;
      end else begin
        gain_d = rem_gain;
      end
    end
    cut_d = cutoff_switch_pos;
    if (cut_remote) begin
      if (rem_cut <= `CUT_1MHZ) begin
        cut_d = rem_cut;
      end else begin
        cut_d = cut_q;                            // illegal code holds
      end
    end
  end

  // ========================================================
  // status conditions and events
  assign ovl_cond = out_over_pos | out_over_neg
                  | common_mode_over | offset_trim_fail;

  always_comb begin
    events                = '0;
    events[`EV_GAIN]      = (gain_d != gain_q);
    events[`EV_CUT]       = (cut_d != cut_q);
    events[`EV_OVL]       = ovl_cond & ~ovl_q;
    events[`EV_COMP_LOST] = comp_q & ~offset_in_window;
    events[`EV_BAD_CODE]  = (gain_remote && rem_gain == `GAIN_UNDEF)
                          | (cut_remote && rem_cut > `CUT_1MHZ);
  end

  // ========================================================
  // bus phases
  assign addr_ph = hsel & htrans[1] & hready;
  assign wr_ph   = wr_q & ready_q;

  assign status_w = {21'h000000, settle_q, comp_q, ovl_q,
                     cut_remote, gain_remote, cut_q, gain_q};

  // ========================================================
  // register next values: set beats write-one-to-clear
  always_comb begin
    ctrl_d  = ctrl_q;
    mask_d  = mask_q;
    ist_d   = ist_q;
    rdata_d = rdata_q;
    if (wr_ph && addr_q == `REG_CTRL) begin
      ctrl_d = hwdata[1:0];
    end
    if (wr_ph && addr_q == `REG_IRQ_MASK) begin
      mask_d = hwdata[`EV_W-1:0];
    end
    if (wr_ph && addr_q == `REG_IRQ_STATUS) begin
      ist_d = ist_q & ~hwdata[`EV_W-1:0];
    end
    ist_d = ist_d | events;
    if (addr_ph && !hwrite) begin
      unique case (haddr[7:0])
        `REG_STATUS:     rdata_d = status_w;
        `REG_IRQ_STATUS: rdata_d = {27'h0000000, ist_q};
        `REG_IRQ_MASK:   rdata_d = {27'h0000000, mask_q};
        `REG_CTRL:       rdata_d = {30'h00000000, ctrl_q};
        default:         rdata_d = 32'h00000000;
      endcase
    end
  end

  // ========================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_q   <= `GAIN_X1000;
      cut_q    <= `CUT_100HZ;
      ovl_q    <= 1'b0;
      comp_q   <= 1'b0;
      settle_q <= 1'b0;
      ctrl_q   <= `CTRL_RESET;
      mask_q   <= `IRQ_MASK_RESET;
      ist_q    <= '0;
      irq_q    <= 1'b0;
      wr_q     <= 1'b0;
      addr_q   <= 8'h00;
      rdata_q  <= 32'h00000000;
      ready_q  <= 1'b1;
    end else if (ce) begin
      gain_q   <= gain_d;
      cut_q    <= cut_d;
      ovl_q    <= ovl_cond;
      comp_q   <= offset_in_window;
      settle_q <= settle_busy | (gain_d != gain_q);
      ctrl_q   <= ctrl_d;
      mask_q   <= mask_d;
      ist_q    <= ist_d;
      irq_q    <= |(ist_d & mask_d);
      wr_q     <= addr_ph & hwrite;
      addr_q   <= {haddr[7:2], 2'h0};
      rdata_q  <= rdata_d;
      ready_q  <= 1'b1;                           // zero wait states
    end
  end

  // ========================================================
  // outputs: open-collector lines drive low, enable low while true
  assign gain_code          = gain_q;
  assign cutoff_code        = cut_q;
  assign gain_settling      = settle_q;
  assign overload_flag_n    = 1'b0;
  assign overload_flag_oe_n = ~ovl_q;
  assign offset_ok_n        = 1'b0;
  assign offset_ok_oe_n     = ~comp_q;
  assign irq                = irq_q;
  assign hrdata             = rdata_q;
  assign hreadyout          = ready_q;
  assign hresp              = 1'b0;

  // ========================================================
  // checks
  manual_gain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && gain_switch_pos != `GAIN_REMOTE_POS
    |=> gain_code == $past(gain_switch_pos))
    else $error("manual gain not followed");

  manual_cut_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && cutoff_switch_pos != `CUT_REMOTE_POS
    |=> cutoff_code == $past(cutoff_switch_pos))
    else $error("manual cut-off not followed");

  remote_indep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && ctrl_q[`CTRL_CUT_EN] && cutoff_switch_pos == `CUT_REMOTE_POS
    && gain_switch_pos != `GAIN_REMOTE_POS && rem_cut <= `CUT_1MHZ
    |=> cutoff_code == $past(rem_cut))
    else $error("cut-off remote blocked by gain path");

  remote_gain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && gain_remote && rem_gain != `GAIN_UNDEF
    |=> gain_code == $past(rem_gain))
    else $error("remote gain code not applied");

  bad_gain_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && gain_remote && rem_gain == `GAIN_UNDEF
    |=> gain_code == `GAIN_X1000 && ist_q[`EV_BAD_CODE])
    else $error("undefined gain code not defaulted");

  cut_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && cut_remote && rem_cut > `CUT_1MHZ
    |=> cutoff_code == $past(cutoff_code) && ist_q[`EV_BAD_CODE])
    else $error("illegal cut-off code not held");

  settle_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && gain_d != gain_q |=> gain_settling [*8])
    else $error("settling window too short");

  ovl_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (out_over_pos || out_over_neg || common_mode_over
           || offset_trim_fail)
    |=> !overload_flag_oe_n && !overload_flag_n)
    else $error("overload not driven low");

  comp_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !offset_in_window |=> offset_ok_oe_n)
    else $error("offset line held low outside window");

  status_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(overload_flag_oe_n) |-> $past(ovl_cond))
    else $error("overload line pulled without cause");

  stable_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(rem_gain) |-> $past(ce))
    else $error("remote gain moved while frozen");

endmodule

/* remote_ctrl_model.sv */
// controller side of the remote lines: drives the select lines and pulls
// up both open-collector status outputs
// assumes codes come from the bench in the hclk domain
`timescale 1ns/1ps

module remote_ctrl_model (
  input  wire logic       hclk,
  input  wire logic [1:0] want_gain,
  input  wire logic [3:0] want_cut,
  input  wire logic       overload_flag_n,
  input  wire logic       overload_flag_oe_n,
  input  wire logic       offset_ok_n,
  input  wire logic       offset_ok_oe_n,
  output logic            gain_sel_bit0,
  output logic            gain_sel_bit1,
  output logic            cutoff_sel_bit0,
  output logic            cutoff_sel_bit1,
  output logic            cutoff_sel_bit2,
  output logic            cutoff_sel_bit3,
  output logic            ovl_line,
  output logic            comp_line
);
  // ==========================================================
  // select lines
  // one code per group, bit 1 / bit 3 being the high line
  always @(posedge hclk) begin
    {gain_sel_bit1, gain_sel_bit0} <= want_gain;
    {cutoff_sel_bit3, cutoff_sel_bit2} <= want_cut[3:2];
    {cutoff_sel_bit1, cutoff_sel_bit0} <= want_cut[1:0];
  end

  // ==========================================================
  // status lines
  // a released output floats up to the pull-up level
  assign ovl_line  = overload_flag_oe_n ? 1'b1 : overload_flag_n;
  assign comp_line = offset_ok_oe_n ? 1'b1 : offset_ok_n;
endmodule

/* amp_remote_decoder_test.sv */
// self-checking bench of the remote control decoder
// assumes the decoder, the controller model and the defines header
`timescale 1ns/1ps
`include "amp_remote_defines.svh"

module amp_remote_decoder_test;
  localparam int SETTLE = 20;
  localparam int STABLE = 3;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        ce      = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [1:0]  want_gain = 2'h0;
  logic [1:0]  gain_pos  = 2'h0;
  logic [3:0]  want_cut  = 4'h0;
  logic [3:0]  cut_pos   = 4'h0;
  logic [3:0]  cause     = 4'h0;
  logic        in_win    = 1'b0;
  logic [31:0] lfsr_q    = 32'h4BC31C81;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic [1:0]  gain_code;
  logic [3:0]  cutoff_code;
  logic        hreadyout, hresp, gain_settling, irq;
  logic        overload_flag_n, overload_flag_oe_n;
  logic        offset_ok_n, offset_ok_oe_n, ovl_line, comp_line;
  logic        g0, g1, c0, c1, c2, c3;
  int          err_total = 0;
  int          n_tests   = 0;
  int          cut_m     = 0;
  logic [1:0]  gseq [4]  = '{2'h2, 2'h0, 2'h1, 2'h3};

  always #5 hclk = ~hclk;

  // ==========================================================
  // design and controller
  amp_remote_decoder #(.SETTLE_CYC(SETTLE), .STABLE_CYC(STABLE)) i_amp_remote_decoder (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .gain_sel_bit0(g0), .gain_sel_bit1(g1),
    .cutoff_sel_bit0(c0), .cutoff_sel_bit1(c1), .cutoff_sel_bit2(c2),
    .cutoff_sel_bit3(c3), .gain_switch_pos(gain_pos),
    .cutoff_switch_pos(cut_pos), .out_over_pos(cause[0]),
    .out_over_neg(cause[1]), .common_mode_over(cause[2]),
    .offset_trim_fail(cause[3]), .offset_in_window(in_win),
    .gain_code(gain_code), .cutoff_code(cutoff_code),
    .gain_settling(gain_settling), .overload_flag_n(overload_flag_n),
    .overload_flag_oe_n(overload_flag_oe_n), .offset_ok_n(offset_ok_n),
    .offset_ok_oe_n(offset_ok_oe_n), .irq(irq));
  remote_ctrl_model i_remote_ctrl_model (
    .hclk(hclk), .want_gain(want_gain), .want_cut(want_cut),
    .overload_flag_n(overload_flag_n),
    .overload_flag_oe_n(overload_flag_oe_n), .offset_ok_n(offset_ok_n),
    .offset_ok_oe_n(offset_ok_oe_n), .gain_sel_bit0(g0),
    .gain_sel_bit1(g1), .cutoff_sel_bit0(c0), .cutoff_sel_bit1(c1),
    .cutoff_sel_bit2(c2), .cutoff_sel_bit3(c3), .ovl_line(ovl_line),
    .comp_line(comp_line));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    $display("CHECK FAILED t=%0t timeout %s", $time, what);
    err_total++;
    print_verdict();
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input string what);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      err_total++;
    end
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp,
                         input string what);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      err_total++;
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // one single AHB-Lite transfer, read data taken at the data-phase edge
  task automatic ahb_xfer(input logic [7:0] a, input logic w,
                          input logic [31:0] wd, output logic [31:0] r);
    int n;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) timed_out("address phase");
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) timed_out("data phase");
    r = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb_xfer(a, 1'b0, 32'h0, r);
    chk_word(r, exp, "register read");
    chk_pin({3'h0, hresp}, 4'h0, "bus response");
  endtask

  // bounded wait for both effective codes, then compare
  task automatic wait_codes(input logic [1:0] eg, input logic [3:0] ec);
    int n;
    n = 0;
    while ((gain_code !== eg || cutoff_code !== ec) && n < 40) begin
      @(posedge hclk);
      #1;
      n++;
    end
    if (n >= 40) timed_out("code change");
    chk_pin({2'h0, gain_code}, {2'h0, eg}, "gain code");
    chk_pin(cutoff_code, ec, "cut-off code");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`REG_STATUS, 32'h000000C0);
    rd_chk(`REG_IRQ_MASK, 32'h0);
    rd_chk(`REG_CTRL, 32'h3);
    ahb_xfer(8'h10, 1'b1, 32'hFFFFFFFF, rd);
    rd_chk(8'h10, 32'h0);
    // every remote gain code, 11 falling back to x1000
    foreach (gseq[i]) begin
      want_gain <= gseq[i];
      wait_codes((gseq[i] == 2'h3) ? 2'h0 : gseq[i], 4'h0);
      chk_pin({3'h0, gain_settling}, 4'h1, "settle start");
      wait_cyc(SETTLE - 4);
      chk_pin({3'h0, gain_settling}, 4'h1, "settle held");
      wait_cyc(8);
      chk_pin({3'h0, gain_settling}, 4'h0, "settle end");
    end
    rd_chk(`REG_IRQ_STATUS, 32'h11);
    // a one-cycle pulse on a gain line must not reach the gain
    want_gain <= 2'h0;
    wait_cyc(2);
    want_gain <= 2'h2;
    @(posedge hclk);
    want_gain <= 2'h0;
    wait_cyc(30);
    chk_pin({2'h0, gain_code}, 4'h0, "glitch ignored");
    // the bad code is gone now, so the clear sticks
    ahb_xfer(`REG_IRQ_STATUS, 1'b1, 32'h1F, rd);
    rd_chk(`REG_IRQ_STATUS, 32'h0);
    // cut-off codes 8 down to 0, then random legal ones
    for (int c = 8; c >= 0; c--) begin
      want_cut <= 4'(c);
      cut_m = c;
      wait_codes(2'h0, 4'(cut_m));
    end
    for (int k = 0; k < 6; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      cut_m = int'(lfsr_q % 9);
      want_cut <= 4'(cut_m);
      wait_codes(2'h0, 4'(cut_m));
    end
    want_cut <= 4'hB;
    wait_cyc(30);
    chk_pin(cutoff_code, 4'(cut_m), "illegal cut-off held");
    // gain manual while cut-off stays remote, then cut-off manual
    gain_pos  <= 2'h1;
    want_gain <= 2'h2;
    wait_codes(2'h1, 4'(cut_m));
    want_cut <= 4'h5;
    wait_codes(2'h1, 4'h5);
    cut_pos <= 4'h3;
    wait_codes(2'h1, 4'h3);
    wait_cyc(30);
    rd_chk(`REG_STATUS, 32'h0000000D);
    // a low clock enable freezes the selection
    ce       <= 1'b0;
    gain_pos <= 2'h2;
    wait_cyc(10);
    chk_pin({2'h0, gain_code}, 4'h1, "frozen by enable");
    ce <= 1'b1;
    wait_codes(2'h2, 4'h3);
    gain_pos <= 2'h0;
    cut_pos  <= 4'h0;
    wait_codes(2'h2, 4'h5);
    // remote gain disabled in control falls back to the selector
    ahb_xfer(`REG_CTRL, 1'b1, 32'h2, rd);
    wait_codes(2'h0, 4'h5);
    ahb_xfer(`REG_CTRL, 1'b1, 32'h3, rd);
    wait_codes(2'h2, 4'h5);
    // each overload cause alone pulls the overload line low
    for (int i = 0; i < 4; i++) begin
      cause <= 4'h1 << i;
      wait_cyc(3);
      chk_pin({3'h0, ovl_line}, 4'h0, "overload low");
      cause <= 4'h0;
      wait_cyc(3);
      chk_pin({3'h0, ovl_line}, 4'h1, "overload released");
    end
    in_win <= 1'b1;
    wait_cyc(3);
    chk_pin({3'h0, comp_line}, 4'h0, "offset ok low");
    in_win <= 1'b0;
    wait_cyc(3);
    chk_pin({3'h0, comp_line}, 4'h1, "offset ok released");
    // interrupt: unmasked overload event raises irq, w1c drops it
    ahb_xfer(`REG_IRQ_STATUS, 1'b1, 32'h1F, rd);
    ahb_xfer(`REG_IRQ_MASK, 1'b1, 32'h04, rd);
    rd_chk(`REG_IRQ_MASK, 32'h04);
    cause <= 4'h2;
    wait_cyc(4);
    chk_pin({3'h0, irq}, 4'h1, "irq raised");
    cause <= 4'h0;
    ahb_xfer(`REG_IRQ_STATUS, 1'b1, 32'h04, rd);
    wait_cyc(2);
    chk_pin({3'h0, irq}, 4'h0, "irq cleared");
    in_win <= 1'b1;
    wait_cyc(3);
    in_win <= 1'b0;
    wait_cyc(3);
    chk_pin({3'h0, irq}, 4'h0, "masked event");
    rd_chk(`REG_IRQ_STATUS, 32'h08);
    print_verdict();
  end
endmodule
